// [frwsp_pkg.sv]
`default_nettype none

package frwsp_pkg;

    // ********************************
    // Flash geometry
    // ********************************
    localparam int unsigned ADDR_W = 16;
    // Fixed region split; the largest boot section starts exactly here
    localparam logic [15:0] NO_READ_WHILE_WRITE_REGION_START = 16'hf000;
    localparam logic [15:0] BOOT_START_FUSE_0 = 16'hf000;
    localparam logic [15:0] BOOT_START_FUSE_1 = 16'hf800;
    localparam logic [15:0] BOOT_START_FUSE_2 = 16'hfc00;
    localparam logic [15:0] BOOT_START_FUSE_3 = 16'hfe00;

    // ********************************
    // Lock bits, 0 means programmed
    // ********************************
    localparam int unsigned LOCK_W = 4;
    localparam logic [3:0] LOCK_RESET = 4'hf;
    localparam int unsigned LOCK_APP_WR = 0;
    localparam int unsigned LOCK_APP_RD = 1;
    localparam int unsigned LOCK_BOOT_WR = 2;
    localparam int unsigned LOCK_BOOT_RD = 3;

    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_LOCK = 8'h04;
    localparam logic [7:0] OFS_BOOT_CFG = 8'h08;
    localparam logic [7:0] OFS_REJECT_CNT = 8'h0c;
    localparam int unsigned CS_BUSY_BIT = 0;
    localparam int unsigned CS_ACTIVE_BIT = 1;
    localparam int unsigned CS_REJECT_BIT = 2;
    localparam int unsigned CS_STALL_BIT = 3;
    localparam logic [7:0] REJECT_CNT_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ********************************
    // Commands and carriers
    // ********************************
    typedef enum logic [1:0] {
        CMD_NONE  = 2'h0,
        CMD_ERASE = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_LOCK  = 2'h3
    } frwsp_cmd_type;

    typedef struct packed {
        frwsp_cmd_type cmd;
        logic [15:0]   pc;
        logic [15:0]   addr;
        logic [3:0]    lock_data;
    } frwsp_spm_type;

    typedef struct packed {
        frwsp_cmd_type op;
        logic [15:0]   addr;
    } frwsp_flash_type;

endpackage

`default_nettype wire

// [frwsp_lock_store.sv]
`timescale 1ns/1ps
`default_nettype none

module frwsp_lock_store (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       prog_en,
    input  wire logic [3:0] prog_val,
    input  wire logic       erase_all,
    output logic      [3:0] lock_q
);

    logic [3:0] lock_d;

    // ********************************
    // Program only; erase restores
    // ********************************
    always_comb begin
        lock_d = lock_q;
        if (erase_all) begin
            lock_d = frwsp_pkg::LOCK_RESET;
        end else if (prog_en) begin
            // Bits can only go to programmed, never back
            lock_d = lock_q & prog_val;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_q <= frwsp_pkg::LOCK_RESET;
        end else begin
            lock_q <= lock_d;
        end
    end

endmodule

`default_nettype wire

// [frwsp_top.sv]
// What this block does
// - Flash erase, write or lock setting starts only when the requesting code sits in the boot section.
// - A request from the boot section may target any flash address, boot pages included.
// - Flash splits into application and boot sections sized by the boot size fuses.
// - Application pages obey the application lock set, boot pages the boot section lock set.
// - A fixed boundary splits flash into read-while-write and no-read-while-write regions.
// - Programming a read-while-write page keeps the core running with reads allowed elsewhere.
// - Programming a no-read-while-write page stalls the core for the whole operation.
// - The region of an operation is judged from its target page address, not the fetch address.
// - The boot section always lies inside the no-read-while-write region.
// - The busy flag reads one for as long as the read-while-write region is blocked.
// - The busy flag stays set after programming until software clears it.
// - Lock pair 11 allows all, 10 bars writes, 00 bars writes and cross reads, 01 bars cross reads.
// - Lock bits may be programmed by software or pins but cleared only by chip erase or sys_rst.
`timescale 1ns/1ps
`default_nettype none

module frwsp_top (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic      [31:0]               hrdata,
    // Fuse and programming-interface pins
    input  wire logic [1:0]                boot_size_fuses,
    input  wire logic                      chip_erase_pin,
    input  wire logic                      lock_prog_pin,
    input  wire logic [3:0]                lock_prog_val_pin,
    // Core store_program_memory_op requests
    input  wire logic                      spm_valid,
    input  wire frwsp_pkg::frwsp_spm_type  spm_req,
    output logic                           spm_ready,
    output logic                           spm_reject_q,
    // Core load_program_memory_op checks
    input  wire logic [15:0]               lpm_pc,
    input  wire logic [15:0]               lpm_addr,
    output logic                           lpm_allow,
    // Core read control
    output logic                           rww_read_block,
    output logic                           core_stall,
    // Flash array
    output logic                           flash_start_q,
    output frwsp_pkg::frwsp_flash_type     flash_cmd_q,
    input  wire logic                      flash_done
);

    // ********************************
    // Types and helpers
    // ********************************
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b001,
        ST_PROG_RWW  = 3'b010,
        ST_PROG_NO_READ_WHILE_WRITE_REGION = 3'b100
    } frwsp_state_type;

    function automatic logic in_no_read_while_write_region(input logic [15:0] addr);
        in_no_read_while_write_region = (addr >= frwsp_pkg::NO_READ_WHILE_WRITE_REGION_START);
    endfunction

    function automatic logic in_boot(input logic [15:0] addr, input logic [15:0] start);
        in_boot = (addr >= start);
    endfunction

    function automatic logic [7:0] word_ofs(input logic [31:0] addr);
        word_ofs = {addr[7:2], 2'h0};
    endfunction

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [1:0] fuse_s1_q;
    logic [1:0] fuse_s2_q;
    logic       erase_s1_q;
    logic       erase_s2_q;
    logic       lprog_s1_q;
    logic       lprog_s2_q;
    logic [3:0] lval_s1_q;
    logic [3:0] lval_s2_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fuse_s1_q  <= 2'h0;
            fuse_s2_q  <= 2'h0;
            erase_s1_q <= 1'b0;
            erase_s2_q <= 1'b0;
            lprog_s1_q <= 1'b0;
            lprog_s2_q <= 1'b0;
            lval_s1_q  <= 4'hf;
            lval_s2_q  <= 4'hf;
        end else begin
            fuse_s1_q  <= boot_size_fuses;
            fuse_s2_q  <= fuse_s1_q;
            erase_s1_q <= chip_erase_pin;
            erase_s2_q <= erase_s1_q;
            lprog_s1_q <= lock_prog_pin;
            lprog_s2_q <= lprog_s1_q;
            lval_s1_q  <= lock_prog_val_pin;
            lval_s2_q  <= lval_s1_q;
        end
    end

    // ********************************
    // Section sizing
    // ********************************
    logic [15:0] boot_start;

    // Every start is at or above the region boundary
    always_comb begin
        unique case (fuse_s2_q)
            2'h0:    boot_start = frwsp_pkg::BOOT_START_FUSE_0;
            2'h1:    boot_start = frwsp_pkg::BOOT_START_FUSE_1;
            2'h2:    boot_start = frwsp_pkg::BOOT_START_FUSE_2;
            default: boot_start = frwsp_pkg::BOOT_START_FUSE_3;
        endcase
    end

    // ********************************
    // Lock store
    // ********************************
    logic [3:0] lock_q;
    logic       sw_lock_en;
    logic [3:0] sw_lock_val;
    logic       lock_prog_en;
    logic [3:0] lock_prog_val;

    assign lock_prog_en  = sw_lock_en | lprog_s2_q;
    assign lock_prog_val = (sw_lock_en ? sw_lock_val : 4'hf)
                         & (lprog_s2_q ? lval_s2_q : 4'hf);

    frwsp_lock_store u_lock (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .prog_en   (lock_prog_en),
        .prog_val  (lock_prog_val),
        .erase_all (erase_s2_q),
        .lock_q    (lock_q)
    );

    // ********************************
    // Request checks
    // ********************************
    logic from_boot;
    logic tgt_boot;
    logic wr_locked;
    logic spm_ok;
    logic spm_take;
    logic spm_flash;

    assign from_boot = in_boot(spm_req.pc, boot_start);
    assign tgt_boot  = in_boot(spm_req.addr, boot_start);
    // Second bit of a pair low bars writes
    assign wr_locked = tgt_boot ? ~lock_q[frwsp_pkg::LOCK_BOOT_WR]
                                : ~lock_q[frwsp_pkg::LOCK_APP_WR];
    assign spm_flash = (spm_req.cmd == frwsp_pkg::CMD_ERASE)
                     || (spm_req.cmd == frwsp_pkg::CMD_WRITE);
    assign spm_ok    = from_boot && !(spm_flash && wr_locked)
                     && (spm_req.cmd != frwsp_pkg::CMD_NONE);

    frwsp_state_type state_q;

    assign spm_ready  = (state_q == ST_IDLE);
    assign spm_take   = spm_valid && spm_ready;
    assign sw_lock_en = spm_take && spm_ok && (spm_req.cmd == frwsp_pkg::CMD_LOCK);
    assign sw_lock_val = spm_req.lock_data;

    // Cross-section reads gated by the target section's lock pair
    always_comb begin
        lpm_allow = 1'b1;
        if (in_boot(lpm_pc, boot_start) && !in_boot(lpm_addr, boot_start)) begin
            lpm_allow = lock_q[frwsp_pkg::LOCK_APP_RD];
        end else if (!in_boot(lpm_pc, boot_start) && in_boot(lpm_addr, boot_start)) begin
            lpm_allow = lock_q[frwsp_pkg::LOCK_BOOT_RD];
        end
    end

    // ********************************
    // Programming sequencer
    // ********************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (spm_take && spm_ok && spm_flash) begin
                        // Target address picks the region
                        if (in_no_read_while_write_region(spm_req.addr)) begin
                            state_q <= ST_PROG_NO_READ_WHILE_WRITE_REGION;
                        end else begin
                            state_q <= ST_PROG_RWW;
                        end
                    end
                end
                ST_PROG_RWW: begin
                    if (flash_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PROG_NO_READ_WHILE_WRITE_REGION: begin
                    if (flash_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_start_q <= 1'b0;
            flash_cmd_q   <= '0;
        end else begin
            flash_start_q <= spm_take && spm_ok && spm_flash;
            if (spm_take && spm_ok && spm_flash) begin
                flash_cmd_q.op   <= spm_req.cmd;
                flash_cmd_q.addr <= spm_req.addr;
            end
        end
    end

    // Whole array unreadable while the boot-side region is programmed
    assign core_stall = (state_q == ST_PROG_NO_READ_WHILE_WRITE_REGION);

    // ********************************
    // Busy flag
    // ********************************
    logic busy_q;
    logic busy_clr;

    // Set on a read-while-write start; only software clears it, never mid-operation
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (spm_take && spm_ok && spm_flash && !in_no_read_while_write_region(spm_req.addr)) begin
            busy_q <= 1'b1;
        end else if (busy_clr && state_q != ST_PROG_RWW) begin
            busy_q <= 1'b0;
        end
    end

    // Reads of the other region stay open; only this region is fenced
    assign rww_read_block = busy_q;

    // ********************************
    // AHB-Lite register slave
    // ********************************
    logic       ap_wr_q;
    logic [7:0] ap_ofs_q;
    logic       ap_take;
    logic       reject_q;
    logic       reject_clr;
    logic [7:0] reject_cnt_q;
    logic       spm_rej;

    assign ap_take = hsel && hready && (htrans == frwsp_pkg::HTRANS_NONSEQ);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ap_wr_q  <= 1'b0;
            ap_ofs_q <= 8'h00;
        end else if (hready) begin
            ap_wr_q  <= ap_take && hwrite;
            ap_ofs_q <= word_ofs(haddr);
        end
    end

    // Zero-wait slave; unmapped offsets read zero and ignore writes
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign busy_clr   = ap_wr_q && (ap_ofs_q == frwsp_pkg::OFS_CTRL_STATUS)
                      && hwdata[frwsp_pkg::CS_BUSY_BIT];
    assign reject_clr = ap_wr_q && (ap_ofs_q == frwsp_pkg::OFS_CTRL_STATUS)
                      && hwdata[frwsp_pkg::CS_REJECT_BIT];
    assign spm_rej    = spm_take && !spm_ok;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            spm_reject_q <= 1'b0;
        end else begin
            spm_reject_q <= spm_rej;
        end
    end

    // New reject beats a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reject_q <= 1'b0;
        end else if (spm_rej) begin
            reject_q <= 1'b1;
        end else if (reject_clr) begin
            reject_q <= 1'b0;
        end
    end

    // Saturates rather than wrapping
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reject_cnt_q <= frwsp_pkg::REJECT_CNT_RESET;
        end else if (spm_rej && reject_cnt_q != 8'hff) begin
            reject_cnt_q <= reject_cnt_q + 8'h01;
        end
    end

    logic [31:0] rd_d;

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (word_ofs(haddr))
            frwsp_pkg::OFS_CTRL_STATUS: begin
                rd_d[frwsp_pkg::CS_BUSY_BIT]   = busy_q;
                rd_d[frwsp_pkg::CS_ACTIVE_BIT] = (state_q != ST_IDLE);
                rd_d[frwsp_pkg::CS_REJECT_BIT] = reject_q;
                rd_d[frwsp_pkg::CS_STALL_BIT]  = core_stall;
            end
            frwsp_pkg::OFS_LOCK: begin
                rd_d[3:0] = lock_q;
            end
            frwsp_pkg::OFS_BOOT_CFG: begin
                rd_d[17:16] = fuse_s2_q;
                rd_d[15:0]  = boot_start;
            end
            frwsp_pkg::OFS_REJECT_CNT: begin
                rd_d[7:0] = reject_cnt_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // Captured at the address edge, so status is as of the request
    logic [31:0] hrdata_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    // Still zero wait: the data phase shows the flop directly
    assign hrdata = hrdata_q;

endmodule

`default_nettype wire

// [frwsp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module frwsp_monitor (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       hsel,
    input wire logic [31:0]                haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic [31:0]                hwdata,
    input wire logic                       hready,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic                       spm_valid,
    input wire frwsp_pkg::frwsp_spm_type   spm_req,
    input wire logic                       spm_ready,
    input wire logic                       spm_reject_q,
    input wire logic                       rww_read_block,
    input wire logic                       core_stall,
    input wire logic                       flash_start_q,
    input wire frwsp_pkg::frwsp_flash_type flash_cmd_q,
    input wire logic                       flash_done
);
    // ************************************
    // Data phase of a control write
    // ************************************
    logic ctrl_wr_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_wr_q <= 1'b0;
        end else if (hready) begin
            ctrl_wr_q <= hsel && hwrite && (htrans == frwsp_pkg::HTRANS_NONSEQ)
                         && (haddr[7:0] == frwsp_pkg::OFS_CTRL_STATUS);
        end
    end

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ************************************
    // Checks
    // ************************************
    ahb_zero_wait_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero wait okay");
    app_reject_a: assert property (spm_valid && spm_ready
        && spm_req.pc < frwsp_pkg::NO_READ_WHILE_WRITE_REGION_START |=> spm_reject_q && !flash_start_q)
        else $error("request from application code not refused");
    start_cause_a: assert property (flash_start_q |-> $past(spm_valid)
        && $past(spm_ready) && flash_cmd_q.addr == $past(spm_req.addr)
        && flash_cmd_q.op == $past(spm_req.cmd))
        else $error("flash start without matching request");
    rww_busy_a: assert property (flash_start_q
        && flash_cmd_q.addr < frwsp_pkg::NO_READ_WHILE_WRITE_REGION_START |-> rww_read_block && !core_stall)
        else $error("read while write page op not flagged busy");
    no_read_while_write_region_stall_a: assert property (flash_start_q
        && flash_cmd_q.addr >= frwsp_pkg::NO_READ_WHILE_WRITE_REGION_START |-> core_stall)
        else $error("no read while write page op did not stall");
    stall_hold_a: assert property (core_stall && !flash_done |=> core_stall)
        else $error("stall dropped before flash done");
    stall_end_a: assert property (core_stall && flash_done |=> !core_stall && spm_ready)
        else $error("stall not ended by flash done");
    busy_hold_a: assert property (rww_read_block
        && !(ctrl_wr_q && hwdata[0]) |=> rww_read_block)
        else $error("busy flag cleared without software");
    reject_quiet_a: assert property (spm_reject_q |-> !flash_start_q
        && !core_stall && $stable(rww_read_block))
        else $error("refused request touched flash or busy");
    busy_ready_a: assert property (flash_start_q |-> !spm_ready)
        else $error("sequencer ready while op starts");

    cover property (flash_start_q && core_stall);
    cover property (spm_reject_q);
    cover property ($rose(rww_read_block));
endmodule

bind frwsp_top frwsp_monitor i_monitor (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .spm_valid(spm_valid), .spm_req(spm_req), .spm_ready(spm_ready),
    .spm_reject_q(spm_reject_q), .rww_read_block(rww_read_block),
    .core_stall(core_stall), .flash_start_q(flash_start_q),
    .flash_cmd_q(flash_cmd_q), .flash_done(flash_done)
);

`default_nettype wire

// [frwsp_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none

module frwsp_flash_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] lat,
    output logic            done
);
    // ************************************
    // Page op timer, latency set per test
    // ************************************
    logic [7:0] cnt_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= lat;
            end else if (cnt_q == 8'h01) begin
                cnt_q <= 8'h00;
                done <= 1'b1;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// [frwsp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module frwsp_top_tb;
    localparam logic [15:0] STARTS [4] = '{frwsp_pkg::BOOT_START_FUSE_0,
        frwsp_pkg::BOOT_START_FUSE_1, frwsp_pkg::BOOT_START_FUSE_2, frwsp_pkg::BOOT_START_FUSE_3};
    logic                       clk = 1'b0;
    logic                       sys_rst, hsel, hwrite, hreadyout, hresp, flash_done;
    logic                       chip_erase_pin, lock_prog_pin, spm_valid, spm_ready;
    logic                       spm_reject_q, lpm_allow, rww_read_block, core_stall;
    logic                       flash_start_q;
    logic [31:0]                haddr, hwdata, hrdata, rd;
    logic [1:0]                 htrans, boot_size_fuses;
    logic [3:0]                 lock_prog_val_pin;
    logic [15:0]                lpm_pc, lpm_addr;
    logic [7:0]                 flash_lat;
    frwsp_pkg::frwsp_spm_type   spm_req;
    frwsp_pkg::frwsp_flash_type flash_cmd_q;
    int                         fails, comparisons, cycles;

    always #5 clk = ~clk;

    frwsp_top i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .boot_size_fuses(boot_size_fuses), .chip_erase_pin(chip_erase_pin),
        .lock_prog_pin(lock_prog_pin), .lock_prog_val_pin(lock_prog_val_pin),
        .spm_valid(spm_valid), .spm_req(spm_req), .spm_ready(spm_ready),
        .spm_reject_q(spm_reject_q), .lpm_pc(lpm_pc), .lpm_addr(lpm_addr),
        .lpm_allow(lpm_allow), .rww_read_block(rww_read_block), .core_stall(core_stall),
        .flash_start_q(flash_start_q), .flash_cmd_q(flash_cmd_q), .flash_done(flash_done));
    frwsp_flash_model i_flash (.clk(clk), .sys_rst(sys_rst), .start(flash_start_q),
        .lat(flash_lat), .done(flash_done));

    // ************************************
    // Access tasks
    // ************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        htrans <= frwsp_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        ahb(1'b0, ofs, 32'h0);
        chk(rd, exp);
    endtask
    // Expectation e is {reject pulse, start pulse} in the cycle after the take
    task automatic store_program_memory_op(input frwsp_pkg::frwsp_cmd_type c, input logic [15:0] pc,
                       input logic [15:0] a, input logic [3:0] ld, input logic [1:0] e);
        @(posedge clk);
        spm_valid <= 1'b1;
        spm_req <= {c, pc, a, ld};
        do @(posedge clk); while (spm_ready !== 1'b1);
        spm_valid <= 1'b0;
        @(posedge clk);
        chk({30'h0, spm_reject_q, flash_start_q}, {30'h0, e});
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200 && spm_ready !== 1'b1; i++) @(posedge clk);
        chk({31'h0, spm_ready}, 32'h1);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            give_verdict();
        end
    end

    // ************************************
    // Test sequence
    // ************************************
    initial begin
        {sys_rst, hsel, hwrite, haddr, hwdata, htrans} = {1'b1, 68'h0};
        {chip_erase_pin, lock_prog_pin, spm_valid, spm_req} = '0;
        {lock_prog_val_pin, lpm_pc, lpm_addr, flash_lat} = {4'hf, 32'h0, 8'h0a};
        {boot_size_fuses, fails, comparisons, cycles} = '0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(frwsp_pkg::OFS_CTRL_STATUS, 32'h0);
        rd_chk(frwsp_pkg::OFS_LOCK, {28'h0, frwsp_pkg::LOCK_RESET});
        rd_chk(8'h10, 32'h0);
        for (int f = 0; f < 4; f++) begin
            boot_size_fuses <= f[1:0];
            repeat (3) @(posedge clk);
            rd_chk(frwsp_pkg::OFS_BOOT_CFG, {14'h0, f[1:0], STARTS[f]});
        end
        store_program_memory_op(frwsp_pkg::CMD_WRITE, 16'h0100, 16'h1000, 4'hf, 2'b10);
        store_program_memory_op(frwsp_pkg::CMD_NONE, 16'hfe10, 16'h1000, 4'hf, 2'b10);
        rd_chk(frwsp_pkg::OFS_CTRL_STATUS, 32'h4);
        ahb(1'b1, frwsp_pkg::OFS_CTRL_STATUS, 32'h4);
        // lpm_pc and lpm_addr stay at 0, inside the busy region, and no lpm check is made meanwhile
        store_program_memory_op(frwsp_pkg::CMD_WRITE, 16'hfe10, 16'h1000, 4'hf, 2'b01);
        chk({14'h0, flash_cmd_q}, {14'h0, frwsp_pkg::CMD_WRITE, 16'h1000});
        chk({30'h0, core_stall, rww_read_block}, 32'h1);
        ahb(1'b1, frwsp_pkg::OFS_CTRL_STATUS, 32'h1);
        rd_chk(frwsp_pkg::OFS_CTRL_STATUS, 32'h3);
        wait_idle();
        rd_chk(frwsp_pkg::OFS_CTRL_STATUS, 32'h1);
        ahb(1'b1, frwsp_pkg::OFS_CTRL_STATUS, 32'h1);
        rd_chk(frwsp_pkg::OFS_CTRL_STATUS, 32'h0);
        flash_lat <= 8'h03;
        store_program_memory_op(frwsp_pkg::CMD_ERASE, 16'hfe10, 16'hfd00, 4'hf, 2'b01);
        chk({30'h0, core_stall, rww_read_block}, 32'h2);
        wait_idle();
        store_program_memory_op(frwsp_pkg::CMD_WRITE, 16'hfe10, 16'hfe80, 4'hf, 2'b01);
        chk({30'h0, core_stall, rww_read_block}, 32'h2);
        wait_idle();
        store_program_memory_op(frwsp_pkg::CMD_LOCK, 16'hfe10, 16'h0000, 4'he, 2'b00);
        rd_chk(frwsp_pkg::OFS_LOCK, 32'he);
        store_program_memory_op(frwsp_pkg::CMD_WRITE, 16'hfe10, 16'h1000, 4'hf, 2'b10);
        store_program_memory_op(frwsp_pkg::CMD_WRITE, 16'hfe10, 16'hfe80, 4'hf, 2'b01);
        wait_idle();
        store_program_memory_op(frwsp_pkg::CMD_LOCK, 16'h0100, 16'h0000, 4'h0, 2'b10);
        lock_prog_val_pin <= 4'h7;
        lock_prog_pin <= 1'b1;
        @(posedge clk);
        lock_prog_pin <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(frwsp_pkg::OFS_LOCK, 32'h6);
        lpm_pc <= 16'h0100;
        lpm_addr <= 16'hfe80;
        @(posedge clk);
        chk({31'h0, lpm_allow}, 32'h0);
        lpm_pc <= 16'hfe10;
        lpm_addr <= 16'h1000;
        @(posedge clk);
        chk({31'h0, lpm_allow}, 32'h1);
        chip_erase_pin <= 1'b1;
        repeat (4) @(posedge clk);
        chip_erase_pin <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(frwsp_pkg::OFS_LOCK, 32'hf);
        rd_chk(frwsp_pkg::OFS_REJECT_CNT, 32'h4);
        give_verdict();
    end
endmodule

`default_nettype wire
